// ===== include/srus_defines.svh
// Constants for the safe remote update sequencer.
// Assumes word addressing of the flash, one word per address.
`ifndef SRUS_DEFINES_SVH
`define SRUS_DEFINES_SVH
// ===========================================================
// Switch values
`define SRUS_ON_BPI     32'h000000BB
`define SRUS_ON_SPI     32'hAA995566
// ===========================================================
// Flash map defaults, in words
`define SRUS_SW_ADDR    32'h0000FFFF
`define SRUS_SEG_WORDS  32'h00010000
`define SRUS_UPD_BASE   32'h00800000
`define SRUS_UPD_SEGS   32'h00000010
// ===========================================================
// Payload buffer
`define SRUS_BUF_DEPTH  2
`endif

// ===== include/srus_pkg.sv
// Types shared by the sequencer and its payload buffer.
// Assumes srus_defines.svh holds the numeric constants.
package srus_pkg;
   // ========================================================
   // Flash command
   typedef enum logic [1:0]
   {
      SRUS_OP_ERASE = 2'h0,
      SRUS_OP_PROG  = 2'h1,
      SRUS_OP_READ  = 2'h2
   } srus_op_t;

   typedef struct packed
   {
      srus_op_t    op;
      logic [31:0] addr;
      logic [31:0] data;
   } srus_fl_cmd_t;

   // ========================================================
   // Programmer states
   typedef enum logic [3:0]
   {
      P_IDLE = 4'h0,
      P_ERSW = 4'h1,
      P_ERUP = 4'h3,
      P_PROG = 4'h2,
      P_VRD  = 4'h6,
      P_VCMP = 4'h7,
      P_PSW  = 4'h5,
      P_DONE = 4'h4,
      P_ERR  = 4'hC
   } srus_pst_t;

   // ========================================================
   // Boot decision states
   typedef enum logic [2:0]
   {
      B_IDLE = 3'h0,
      B_RDSW = 3'h1,
      B_WTSW = 3'h3,
      B_WBST = 3'h2,
      B_IPRG = 3'h6,
      B_LOAD = 3'h7
   } srus_bst_t;
endpackage

// ===== hdl/srus_buf.sv
// Small payload buffer between host stream and programmer.
// Assumes one clock; ready and valid on both sides.
`timescale 1ns/1ps
`include "srus_defines.svh"
module srus_buf
   import srus_pkg::*;
#(
   parameter int W     = 32,
   parameter int DEPTH = `SRUS_BUF_DEPTH
)
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         resetn,
   // Fill side
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // Drain side
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   // ========================================================
   // Storage and pointers
   logic [W-1:0]  mem_reg [DEPTH];
   logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic          push, pop, rdy_next;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   always_comb
   begin
      push     = in_valid && in_ready;
      pop      = out_ready && (cnt_reg != '0);
      wp_next  = push ? bump(wp_reg) : wp_reg;
      rp_next  = pop ? bump(rp_reg) : rp_reg;
      cnt_next = cnt_reg + CW'(push) - CW'(pop);
      rdy_next = (cnt_next != CW'(DEPTH));
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
         in_ready <= 1'b0;
      end
      else
      begin
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
         cnt_reg <= cnt_next;
         in_ready <= rdy_next;
      end
   end

   always_ff @(posedge clk)
   begin
      if (push)
         mem_reg[wp_reg] <= in_data;
   end

   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem_reg[rp_reg];
endmodule

// ===== hdl/srus_seq.sv
// Safe remote update sequencer: programmer and boot decision.
// Assumes a flash controller that accepts one command at a time,
// pulses fl_done after erase or program and fl_rd_valid after read.
// Behaviour
// - Jump header is two packets, address then reprogram
// - First packet loads update area address
// - Reprogram restarts at warm boot address
// - Configuration error restarts from address zero
// - Error retry ignores warm boot jump
// - Boot reads from zero, checks switch word
// - Switch ON executes jump, loads update image
// - Switch OFF skips jump, reads on to golden
// - Only the exact value means ON
// - First action erases the switch segment
// - Then erase every update area segment
// - Then program the update bitstream
// - Then read back and compare the update area
// - Write ON value only after verification passes
// - Never touch golden image or jump header
// - Byte-wide ON value is 0x000000BB
// - Serial ON value is the sync word
// - Switch word alone in its own segment
`timescale 1ns/1ps
`include "srus_defines.svh"
module srus_seq
   import srus_pkg::*;
#(
   parameter logic [31:0] SW_ADDR   = `SRUS_SW_ADDR,
   parameter logic [31:0] SEG_WORDS = `SRUS_SEG_WORDS,
   parameter logic [31:0] UPD_BASE  = `SRUS_UPD_BASE,
   parameter logic [31:0] UPD_SEGS  = `SRUS_UPD_SEGS
)
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         resetn,
   // Host control
   input  wire logic         start,
   input  wire logic [31:0]  img_len,
   input  wire logic         mode_spi,
   output logic              busy_reg,
   output logic              done_reg,
   output logic              err_reg,
   output logic              verify_pass_reg,
   // Host payload stream
   input  wire logic         pay_valid,
   input  wire logic [31:0]  pay_data,
   output logic              pay_ready,
   // Flash command port
   output logic              fl_valid_reg,
   output srus_fl_cmd_t      fl_cmd_reg,
   input  wire logic         fl_ready,
   input  wire logic         fl_done,
   input  wire logic         fl_rd_valid,
   input  wire logic [31:0]  fl_rd_data,
   // Configuration side
   input  wire logic         cfg_start,
   input  wire logic         cfg_err,
   output logic              bt_rd_req_reg,
   output logic [31:0]       bt_rd_addr_reg,
   input  wire logic         bt_rd_valid,
   input  wire logic [31:0]  bt_rd_data,
   output logic [31:0]       warm_boot_start_address_reg,
   output logic              internal_reprogram_command_reg,
   output logic              fallback_reg,
   output logic              sel_update_reg,
   output logic              sel_golden_reg,
   output logic [31:0]       load_addr_reg
);
   // ========================================================
   // Helpers
   localparam logic [31:0] SW_SEG = SW_ADDR & ~(SEG_WORDS - 32'h1);

   function automatic logic [31:0] on_val(input logic spi);
      on_val = spi ? `SRUS_ON_SPI : `SRUS_ON_BPI;
   endfunction

   function automatic logic legal(input logic [31:0] a);
      legal = (a >= SW_SEG && a < SW_SEG + SEG_WORDS) ||
              (a >= UPD_BASE && a < UPD_BASE + UPD_SEGS * SEG_WORDS);
   endfunction

   // ========================================================
   // Payload buffer
   logic        bv;
   logic [31:0] bd;
   logic        bpop;

   srus_buf #(.W(32), .DEPTH(`SRUS_BUF_DEPTH)) u_buf
   (
      .clk       (clk),
      .resetn    (resetn),
      .in_valid  (pay_valid),
      .in_data   (pay_data),
      .in_ready  (pay_ready),
      .out_valid (bv),
      .out_data  (bd),
      .out_ready (bpop)
   );

   // ========================================================
   // Programmer
   srus_pst_t    ps_reg, ps_next;
   logic [31:0]  cnt_reg, cnt_next, len_reg, len_next;
   logic [31:0]  rdw_reg, rdw_next;
   logic         wait_reg, wait_next, vok_reg, vok_next;
   logic         fv_next, busy_next, done_next, err_next, vp_next;
   srus_fl_cmd_t cmd_next;

   always_comb
   begin
      ps_next   = ps_reg;
      cnt_next  = cnt_reg;
      len_next  = len_reg;
      rdw_next  = rdw_reg;
      wait_next = wait_reg;
      vok_next  = vok_reg;
      fv_next   = fl_valid_reg && !fl_ready;
      cmd_next  = fl_cmd_reg;
      done_next = done_reg;
      err_next  = err_reg;
      vp_next   = verify_pass_reg;
      bpop      = (ps_reg == P_IDLE) && !start;
      unique case (ps_reg)
         P_IDLE:
            if (start)
            begin
               done_next = 1'b0;
               err_next  = 1'b0;
               vok_next  = 1'b0;
               len_next  = img_len;
               cnt_next  = '0;
               if (img_len > UPD_SEGS * SEG_WORDS)
                  ps_next = P_ERR;
               else
                  ps_next = P_ERSW;
            end
         P_ERSW, P_ERUP, P_PROG, P_PSW:
            if (!wait_reg)
            begin
               if (ps_reg == P_ERSW)
                  cmd_next = '{SRUS_OP_ERASE, SW_SEG, 32'hFFFFFFFF};
               else if (ps_reg == P_ERUP)
                  cmd_next = '{SRUS_OP_ERASE, UPD_BASE + cnt_reg * SEG_WORDS,
                               32'hFFFFFFFF};
               else if (ps_reg == P_PROG)
                  cmd_next = '{SRUS_OP_PROG, UPD_BASE + cnt_reg, bd};
               else
                  cmd_next = '{SRUS_OP_PROG, SW_ADDR, on_val(mode_spi)};
               if (!legal(cmd_next.addr))
                  ps_next = P_ERR;
               else if (ps_reg != P_PROG || bv)
               begin
                  fv_next   = 1'b1;
                  wait_next = 1'b1;
                  bpop      = (ps_reg == P_PROG);
               end
            end
            else if (fl_done)
            begin
               wait_next = 1'b0;
               cnt_next  = cnt_reg + 32'h1;
               if (ps_reg == P_ERSW)
               begin
                  cnt_next = '0;
                  ps_next  = P_ERUP;
               end
               else if (ps_reg == P_ERUP && cnt_next == UPD_SEGS)
               begin
                  cnt_next = '0;
                  ps_next  = (len_reg == '0) ? P_VRD : P_PROG;
               end
               else if (ps_reg == P_PROG && cnt_next == len_reg)
               begin
                  cnt_next = '0;
                  vp_next  = 1'b1;
                  ps_next  = P_VRD;
               end
               else if (ps_reg == P_PSW)
                  ps_next = P_DONE;
            end
         P_VRD:
            if (cnt_reg == len_reg)
            begin
               vok_next = 1'b1;
               vp_next  = 1'b0;
               ps_next  = P_PSW;
            end
            else if (!wait_reg)
            begin
               cmd_next  = '{SRUS_OP_READ, UPD_BASE + cnt_reg, 32'h0};
               fv_next   = 1'b1;
               wait_next = 1'b1;
            end
            else if (fl_rd_valid)
            begin
               wait_next = 1'b0;
               rdw_next  = fl_rd_data;
               ps_next   = P_VCMP;
            end
         P_VCMP:
            if (bv)
            begin
               bpop     = 1'b1;
               cnt_next = cnt_reg + 32'h1;
               if (bd != rdw_reg)
               begin
                  vp_next = 1'b0;
                  ps_next = P_ERR;
               end
               else
                  ps_next = P_VRD;
            end
         P_DONE:
         begin
            done_next = 1'b1;
            ps_next   = P_IDLE;
         end
         P_ERR:
         begin
            err_next = 1'b1;
            ps_next  = P_IDLE;
         end
         default:
            ps_next = P_ERR;
      endcase
      busy_next = (ps_next != P_IDLE);
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ps_reg          <= P_IDLE;
         cnt_reg         <= '0;
         len_reg         <= '0;
         rdw_reg         <= '0;
         wait_reg        <= 1'b0;
         vok_reg         <= 1'b0;
         fl_valid_reg    <= 1'b0;
         fl_cmd_reg      <= '{SRUS_OP_READ, 32'h0, 32'h0};
         busy_reg        <= 1'b0;
         done_reg        <= 1'b0;
         err_reg         <= 1'b0;
         verify_pass_reg <= 1'b0;
      end
      else
      begin
         ps_reg          <= ps_next;
         cnt_reg         <= cnt_next;
         len_reg         <= len_next;
         rdw_reg         <= rdw_next;
         wait_reg        <= wait_next;
         vok_reg         <= vok_next;
         fl_valid_reg    <= fv_next;
         fl_cmd_reg      <= cmd_next;
         busy_reg        <= busy_next;
         done_reg        <= done_next;
         err_reg         <= err_next;
         verify_pass_reg <= vp_next;
      end
   end

   // ========================================================
   // Boot decision
   srus_bst_t   bs_reg, bs_next;
   logic [31:0] wb_next, la_next, ba_next;
   logic        rq_next, ip_next, fb_next, su_next, sg_next;

   always_comb
   begin
      bs_next = bs_reg;
      wb_next = warm_boot_start_address_reg;
      la_next = load_addr_reg;
      ba_next = bt_rd_addr_reg;
      fb_next = fallback_reg;
      su_next = sel_update_reg;
      sg_next = sel_golden_reg;
      rq_next = 1'b0;
      ip_next = 1'b0;
      if (cfg_err || cfg_start)
      begin
         fb_next = cfg_err;
         su_next = 1'b0;
         sg_next = 1'b0;
         la_next = '0;
         ba_next = '0;
         bs_next = B_RDSW;
      end
      else
         unique case (bs_reg)
            B_IDLE: ;
            B_RDSW:
            begin
               rq_next = 1'b1;
               ba_next = SW_ADDR;
               bs_next = B_WTSW;
            end
            B_WTSW:
               if (bt_rd_valid)
               begin
                  if (bt_rd_data == on_val(mode_spi) && !fallback_reg)
                     bs_next = B_WBST;
                  else
                  begin
                     la_next = SW_ADDR + 32'h1;
                     sg_next = 1'b1;
                     bs_next = B_LOAD;
                  end
               end
            B_WBST:
            begin
               wb_next = UPD_BASE;
               bs_next = B_IPRG;
            end
            B_IPRG:
            begin
               ip_next = 1'b1;
               la_next = warm_boot_start_address_reg;
               su_next = 1'b1;
               bs_next = B_LOAD;
            end
            B_LOAD: ;
            default:
               bs_next = B_IDLE;
         endcase
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bs_reg         <= B_IDLE;
         warm_boot_start_address_reg <= '0;
         load_addr_reg  <= '0;
         bt_rd_addr_reg <= '0;
         bt_rd_req_reg  <= 1'b0;
         internal_reprogram_command_reg <= 1'b0;
         fallback_reg   <= 1'b0;
         sel_update_reg <= 1'b0;
         sel_golden_reg <= 1'b0;
      end
      else
      begin
         bs_reg         <= bs_next;
         warm_boot_start_address_reg <= wb_next;
         load_addr_reg  <= la_next;
         bt_rd_addr_reg <= ba_next;
         bt_rd_req_reg  <= rq_next;
         internal_reprogram_command_reg <= ip_next;
         fallback_reg   <= fb_next;
         sel_update_reg <= su_next;
         sel_golden_reg <= sg_next;
      end
   end

   // ========================================================
   // Checks
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   a_first_sw_erase: assert property (
      fl_valid_reg && ps_reg == P_ERSW |-> fl_cmd_reg.addr == SW_SEG)
      else $error("first erase not on switch segment");
   a_erase_all_segs: assert property (
      ps_reg == P_ERUP && ps_next != P_ERUP && ps_next != P_ERR
      |-> cnt_reg == UPD_SEGS - 32'h1)
      else $error("update area not fully erased");
   a_on_after_verify: assert property (
      fl_valid_reg && fl_cmd_reg.op == SRUS_OP_PROG &&
      fl_cmd_reg.addr == SW_ADDR
      |-> vok_reg && fl_cmd_reg.data == on_val(mode_spi))
      else $error("switch programmed without verification");
   a_golden_safe: assert property (
      fl_valid_reg && fl_cmd_reg.op != SRUS_OP_READ
      |-> legal(fl_cmd_reg.addr))
      else $error("write outside switch or update area");
   a_mismatch_err: assert property (
      ps_reg == P_VCMP && bv && bd != rdw_reg
      |=> ps_reg == P_ERR ##1 err_reg && !vok_reg)
      else $error("mismatch did not raise error");
   a_jump_address: assert property (
      bs_reg == B_IPRG |-> warm_boot_start_address_reg == UPD_BASE)
      else $error("warm boot address not update area");
   a_reprog_target: assert property (
      $rose(internal_reprogram_command_reg) |->
      load_addr_reg == warm_boot_start_address_reg && sel_update_reg)
      else $error("reprogram did not resume at warm boot address");
   a_err_restart: assert property (
      cfg_err |=> bs_reg == B_RDSW && bt_rd_addr_reg == 32'h0
      ##1 bt_rd_req_reg && bt_rd_addr_reg == SW_ADDR)
      else $error("error did not restart from zero");
   a_fallback_nojump: assert property (
      fallback_reg |-> !internal_reprogram_command_reg && !sel_update_reg)
      else $error("jump taken during error retry");
   a_off_golden: assert property (
      bs_reg == B_WTSW && bt_rd_valid && !cfg_err && !cfg_start &&
      bt_rd_data != on_val(mode_spi)
      |=> sel_golden_reg && load_addr_reg == SW_ADDR + 32'h1)
      else $error("off switch did not fall through");
endmodule

// ===== verif/srus_flash_model.sv
// Behavioural NOR flash on the sequencer's command port.
// Assumes word addressing and one command in flight at a time.
`timescale 1ns/1ps
module srus_flash_model
   import srus_pkg::*;
#(
   parameter int SEG = 16
)
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         resetn,
   // Command port
   input  wire logic         fl_valid_reg,
   input  wire srus_fl_cmd_t fl_cmd_reg,
   output logic              fl_ready,
   output logic              fl_done,
   output logic              fl_rd_valid,
   output logic [31:0]       fl_rd_data,
   // Speed and fault control
   input  wire logic [3:0]   lat,
   input  wire logic [31:0]  bad_addr
);
   logic [31:0]  mem [0:511];
   srus_fl_cmd_t cur;
   logic         pend;
   logic [3:0]   cnt;

   // ========
   // Array contents
   initial
   begin
      for (int i = 0; i < 512; i++)
         mem[i] = i;
   end

   // ========
   // Accept, wait, answer
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         fl_ready    <= 1'b0;
         fl_done     <= 1'b0;
         fl_rd_valid <= 1'b0;
         fl_rd_data  <= 32'h0;
         pend        <= 1'b0;
         cnt         <= 4'h0;
      end
      else
      begin
         fl_ready    <= 1'b0;
         fl_done     <= 1'b0;
         fl_rd_valid <= 1'b0;
         fl_rd_data  <= ~fl_rd_data;
         if (fl_valid_reg && fl_ready)
         begin
            cur  <= fl_cmd_reg;
            pend <= 1'b1;
            cnt  <= lat;
         end
         else if (pend && cnt != 4'h0)
            cnt <= cnt - 4'h1;
         else if (pend)
         begin
            pend <= 1'b0;
            if (cur.op == SRUS_OP_ERASE)
               for (int i = 0; i < SEG; i++)
                  mem[cur.addr[8:0] + i] = 32'hFFFFFFFF;
            else if (cur.op == SRUS_OP_PROG)
               mem[cur.addr[8:0]] &= cur.data;
            fl_done     <= cur.op != SRUS_OP_READ;
            fl_rd_valid <= cur.op == SRUS_OP_READ;
            if (cur.op == SRUS_OP_READ)
               fl_rd_data <= mem[cur.addr[8:0]] ^ {31'h0, cur.addr == bad_addr};
         end
         else if (fl_valid_reg && cnt != lat)
            cnt <= cnt + 4'h1;
         else if (fl_valid_reg)
            fl_ready <= 1'b1;
      end
   end
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the update sequencer.
// Assumes srus_flash_model stands on the flash command port.
`timescale 1ns/1ps
`include "srus_defines.svh"
module testbench
   import srus_pkg::*;
;
   localparam logic [31:0] SEG   = 32'h10;
   localparam logic [31:0] SEGS  = 32'h2;
   localparam logic [31:0] UBASE = 32'h100;
   localparam logic [31:0] SWA   = 32'hF;
   localparam int          LEN   = 8;
   logic         clk, resetn, start, mode_spi, busy_reg, done_reg, err_reg;
   logic         verify_pass_reg, pay_valid, pay_ready, fl_valid_reg;
   logic         fl_ready, fl_done, fl_rd_valid, cfg_start, cfg_err;
   logic         bt_rd_req_reg, bt_rd_valid, internal_reprogram_command_reg;
   logic         fallback_reg;
   logic         sel_update_reg, sel_golden_reg, bt_go, got_first;
   logic [31:0]  img_len, pay_data, fl_rd_data, bt_rd_addr_reg, bt_rd_data;
   logic [31:0]  warm_boot_start_address_reg, load_addr_reg, bad_addr, bt_word;
   logic [3:0]   lat;
   srus_fl_cmd_t fl_cmd_reg, first_cmd, last_cmd;
   int           num_errors, check_count, n_ops, n_er, n_rd, n_gold;
   int           n_stall, n_internal_reprogram_command;

   srus_seq #(.SW_ADDR(SWA), .SEG_WORDS(SEG), .UPD_BASE(UBASE),
      .UPD_SEGS(SEGS)) uut
   (.clk, .resetn, .start, .img_len, .mode_spi, .busy_reg, .done_reg,
    .err_reg, .verify_pass_reg, .pay_valid, .pay_data, .pay_ready,
    .fl_valid_reg, .fl_cmd_reg, .fl_ready, .fl_done, .fl_rd_valid,
    .fl_rd_data, .cfg_start, .cfg_err, .bt_rd_req_reg, .bt_rd_addr_reg,
    .bt_rd_valid, .bt_rd_data, .warm_boot_start_address_reg,
    .internal_reprogram_command_reg, .fallback_reg,
    .sel_update_reg, .sel_golden_reg, .load_addr_reg);

   srus_flash_model #(.SEG(16)) flash
   (.clk, .resetn, .fl_valid_reg, .fl_cmd_reg, .fl_ready, .fl_done,
    .fl_rd_valid, .fl_rd_data, .lat, .bad_addr);

   // ========
   // Clock, monitors, boot word driver
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(negedge clk)
   begin
      if (internal_reprogram_command_reg)
         n_internal_reprogram_command++;
      if (fl_valid_reg && fl_ready)
      begin
         n_ops++;
         last_cmd = fl_cmd_reg;
         if (!got_first)
            first_cmd = fl_cmd_reg;
         got_first = 1'b1;
         n_er += (fl_cmd_reg.op == SRUS_OP_ERASE);
         n_rd += (fl_cmd_reg.op == SRUS_OP_READ);
         if (fl_cmd_reg.op != SRUS_OP_READ && fl_cmd_reg.addr >= SEG &&
             fl_cmd_reg.addr < UBASE)
            n_gold++;
      end
      bt_rd_valid <= bt_go;
      bt_rd_data  <= bt_go ? bt_word : ~bt_rd_data;
      bt_go       <= 1'b0;
   end

   // ========
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic send_img(input int len);
      int n;
      for (int i = 0; i < len && err_reg !== 1'b1; i++)
      begin
         pay_valid = 1'b1;
         pay_data  = 32'h5AC30000 | i;
         n = 0;
         while (pay_ready !== 1'b1 && err_reg !== 1'b1 && n < 400)
         begin
            n_stall++;
            n++;
            @(negedge clk);
         end
         num_errors += (n == 400);
         @(negedge clk);
      end
      pay_valid = 1'b0;
   endtask

   task automatic do_update(input logic spi, input int len,
                            input logic [31:0] bad, input logic [3:0] sp);
      int n;
      @(posedge clk);
      n_ops = 0;
      n_er = 0;
      n_rd = 0;
      n_gold = 0;
      n_stall = 0;
      got_first = 1'b0;
      @(negedge clk);
      mode_spi = spi;
      img_len = len;
      bad_addr = bad;
      lat = sp;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      if (len <= LEN)
      begin
         send_img(len);
         n = 0;
         while (verify_pass_reg !== 1'b1 && n < 3000)
         begin
            n++;
            @(negedge clk);
         end
         num_errors += (n == 3000);
         send_img(len);
      end
      n = 0;
      while (busy_reg !== 1'b0 && n < 3000)
      begin
         n++;
         @(negedge clk);
      end
      num_errors += (n == 3000);
   endtask

   // ========
   // Scenarios
   task automatic t_update(input logic spi, input logic [3:0] sp);
      do_update(spi, LEN, 32'h0, sp);
      chk(done_reg, 1'b1);
      chk(err_reg, 1'b0);
      chk(first_cmd.op, SRUS_OP_ERASE);
      chk(first_cmd.addr, SWA & ~(SEG - 32'h1));
      chk(n_er, SEGS + 32'h1);
      chk(n_rd, LEN);
      for (int i = 0; i < LEN; i++)
         chk(flash.mem[UBASE + i], 32'h5AC30000 | i);
      chk(flash.mem[SWA], spi ? `SRUS_ON_SPI : `SRUS_ON_BPI);
      chk(last_cmd.addr, SWA);
      chk(n_gold, 0);
      chk(n_stall != 0, 1'b1);
      chk(pay_ready, 1'b1);
      chk(verify_pass_reg, 1'b0);
      $display("test update done");
   endtask

   task automatic t_bad();
      do_update(1'b1, LEN, UBASE + 32'h2, 4'h2);
      chk(err_reg, 1'b1);
      chk(done_reg, 1'b0);
      chk(flash.mem[SWA], 32'hFFFFFFFF);
      $display("test bad image done");
   endtask

   task automatic t_big();
      do_update(1'b0, SEG * SEGS + 32'h1, 32'h0, 4'h0);
      chk(err_reg, 1'b1);
      chk(n_ops, 0);
      $display("test oversize done");
   endtask

   task automatic t_boot(input logic spi, input logic [31:0] w,
                         input logic err, input logic on);
      int n;
      int i0;
      @(negedge clk);
      mode_spi = spi;
      cfg_err = err;
      cfg_start = !err;
      @(negedge clk);
      cfg_err = 1'b0;
      cfg_start = 1'b0;
      n = 0;
      while (bt_rd_req_reg !== 1'b1 && n < 20)
      begin
         n++;
         @(negedge clk);
      end
      num_errors += (n == 20);
      chk(bt_rd_addr_reg, SWA);
      i0 = n_internal_reprogram_command;
      bt_word = w;
      @(posedge clk);
      bt_go = 1'b1;
      repeat (8) @(negedge clk);
      chk(sel_update_reg, on);
      chk(sel_golden_reg, !on);
      chk(load_addr_reg, on ? UBASE : SWA + 32'h1);
      chk(n_internal_reprogram_command - i0, on);
      if (on)
         chk(warm_boot_start_address_reg, UBASE);
      chk(fallback_reg, err);
      $display("test boot done");
   endtask

   task automatic t_reset();
      @(negedge clk);
      resetn = 1'b0;
      @(negedge clk);
      chk({err_reg, fallback_reg, sel_golden_reg, pay_ready}, 4'h0);
      resetn = 1'b1;
      @(negedge clk);
      chk({busy_reg, fallback_reg, sel_update_reg, pay_ready}, 4'h1);
      chk(load_addr_reg, 32'h0);
      $display("test reset done");
   endtask

   // ========
   // Main sequence and watchdog
   initial
   begin
      {resetn, start, mode_spi, pay_valid, cfg_start, cfg_err} = 6'h0;
      {img_len, pay_data, bad_addr, bt_word, bt_rd_data} = 160'h0;
      {bt_go, bt_rd_valid, got_first, lat} = 7'h0;
      {num_errors, check_count, n_ops, n_er, n_rd, n_gold} = 192'h0;
      {n_stall, n_internal_reprogram_command} = 64'h0;
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      t_update(1'b0, 4'h6);
      t_update(1'b1, 4'h0);
      t_bad();
      t_big();
      for (int m = 0; m < 2; m++)
      begin
         t_boot(m[0], m ? `SRUS_ON_SPI : `SRUS_ON_BPI, 1'b0, 1'b1);
         t_boot(m[0], m ? 32'hAA995567 : 32'h000000BA, 1'b0, 1'b0);
         t_boot(m[0], 32'hFFFFFFFF, 1'b0, 1'b0);
         t_boot(m[0], m ? `SRUS_ON_BPI : `SRUS_ON_SPI, 1'b0, 1'b0);
      end
      t_boot(1'b1, `SRUS_ON_SPI, 1'b1, 1'b0);
      t_reset();
      stop_test();
   end

   initial
   begin
      #(40 * 20000);
      num_errors++;
      stop_test();
   end
endmodule
